// file: mcb_basic_cmd.sv
// card-side interpreter for basic commands 0, 3, 4 and 7 to 12
`timescale 1ns/100ps
module mcb_basic_cmd (
   input  wire logic                i_core_clk,
   input  wire logic                i_rst_b,
   input  wire logic                i_link_clk,
   input  wire logic                i_cmd_valid,
   input  wire logic [5:0]          i_cmd_index,
   input  wire logic [31:0]         i_cmd_arg,
   output logic                     o_rsp_valid,
   output mcb_pkg::mcb_rsp_e        o_rsp_kind,
   output logic      [127:0]        o_rsp_payload,
   input  wire logic                i_dat0_in,
   output logic                     o_dat0_out,
   output logic                     o_dat0_oe,
   input  wire logic [15:0]         i_new_address,
   input  wire logic [3:0]          i_vhs_accepted,
   input  wire logic [127:0]        i_card_specific_data,
   input  wire logic [127:0]        i_card_identification,
   input  wire logic                i_data_start,
   input  wire logic                i_prog_start,
   input  wire logic                i_op_done,
   output mcb_pkg::mcb_state_e      o_state,
   output logic      [15:0]         o_relative_card_address,
   output logic      [15:0]         o_driver_stage,
   output logic                     o_selected,
   output logic                     o_vhs_ok,
   output logic                     o_switch_18v,
   output logic                     o_stop_xfer,
   output logic                     o_busy
);
   import mcb_pkg::*;

   function automatic logic [3:0] state_code(input mcb_state_e s);
      case (s)
         ST_IDLE: state_code = CODE_IDLE;
         ST_STBY: state_code = CODE_STBY;
         ST_TRAN: state_code = CODE_TRAN;
         ST_DATA: state_code = CODE_DATA;
         ST_PRG:  state_code = CODE_PRG;
         ST_DIS:  state_code = CODE_DIS;
         default: state_code = CODE_IDLE;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // link domain: command capture, response release, busy drive
   // core state declared first: the link side reads its response word
   typedef struct packed {
      mcb_state_e   state;
      logic [15:0]  relative_card_address;
      logic [15:0]  dsr;
      logic         selected;
      logic         busy;
      logic         vhs_ok;
      logic         sw18;
      logic         stop;
      logic         cmd_seen;
      logic         rsp_tog;
      mcb_rsp_e     rsp_kind;
      logic [127:0] rsp_payload;
   } mcb_core_s;
   mcb_core_s r;
   mcb_core_s next_r;
   typedef struct packed {
      logic         cmd_tog;
      logic [5:0]   cmd_idx;
      logic [31:0]  cmd_arg;
      logic         rsp_seen;
      logic         rsp_valid;
      mcb_rsp_e     rsp_kind;
      logic [127:0] rsp_payload;
      logic         dat0_oe;
   } mcb_link_s;
   mcb_link_s l;
   mcb_link_s next_l;
   logic       link_rst_b;
   logic [1:0] link_in;
   logic       core_rsp_tog;
   logic       core_busy;

   mcb_sync #(.W(1)) u_rst_sync (
      .i_clk (i_link_clk),
      .i_d   (i_rst_b),
      .o_q   (link_rst_b)
   );
   mcb_sync #(.W(2)) u_to_link (
      .i_clk (i_link_clk),
      .i_d   ({core_rsp_tog, core_busy}),
      .o_q   (link_in)
   );

   always_comb begin
      next_l = l;
      next_l.rsp_valid = 1'b0;
      if (i_cmd_valid) begin
         next_l.cmd_idx = i_cmd_index;
         next_l.cmd_arg = i_cmd_arg;
         next_l.cmd_tog = ~l.cmd_tog;
      end
      next_l.rsp_seen = link_in[1];
      if (link_in[1] != l.rsp_seen) begin
         next_l.rsp_valid   = 1'b1;
         next_l.rsp_kind    = r.rsp_kind;
         next_l.rsp_payload = r.rsp_payload;
      end
      next_l.dat0_oe = link_in[0];
      if (!link_rst_b) begin
         next_l = '0;
         next_l.rsp_kind = RSP_R1;
      end
   end
   always_ff @(posedge i_link_clk) begin
      l <= next_l;
   end

   assign o_rsp_valid   = l.rsp_valid;
   assign o_rsp_kind    = l.rsp_kind;
   assign o_rsp_payload = l.rsp_payload;
   assign o_dat0_out    = 1'b0;
   assign o_dat0_oe     = l.dat0_oe;

   ////////////////////////////////////////////////////////////////////////////
   // core domain: command interpretation and card state
   logic        cmd_tog_s;
   logic        cmd_new;
   logic        addr_hit;
   logic [31:0] status;
   logic [3:0]  host_supply_voltage_code;

   mcb_sync #(.W(1)) u_to_core (
      .i_clk (i_core_clk),
      .i_d   (l.cmd_tog),
      .o_q   (cmd_tog_s)
   );

   assign cmd_new  = cmd_tog_s != r.cmd_seen;
   assign addr_hit = l.cmd_arg[ADDR_HI:ADDR_LO] == r.relative_card_address;
   assign status   = {19'h00000, state_code(r.state), 9'h000};
   assign host_supply_voltage_code      = l.cmd_arg[VHS_HI:VHS_LO];

   always_comb begin
      next_r = r;
      next_r.cmd_seen = cmd_tog_s;
      next_r.stop = 1'b0;
      if (i_op_done) begin
         next_r.busy = 1'b0;
         if (r.state == ST_PRG) begin
            next_r.state = ST_TRAN;
         end
         if (r.state == ST_DIS) begin
            next_r.state = ST_STBY;
         end
      end
      if (i_data_start && r.state == ST_TRAN) begin
         next_r.state = ST_DATA;
      end
      if (i_prog_start && r.state == ST_TRAN) begin
         next_r.state = ST_PRG;
         next_r.busy = 1'b1;
      end
      if (cmd_new) begin
         case (l.cmd_idx)
            CMD_GO_IDLE: begin
               next_r.state    = ST_IDLE;
               next_r.relative_card_address      = ADDR_NONE;
               next_r.selected = 1'b0;
               next_r.busy     = 1'b0;
            end
            CMD_PUB_ADDR: begin
               next_r.relative_card_address         = i_new_address;
               if (r.state == ST_IDLE) begin
                  next_r.state = ST_STBY;
               end
               next_r.rsp_kind    = RSP_R6;
               next_r.rsp_payload = {96'h0, i_new_address, status[15:0]};
               next_r.rsp_tog     = ~r.rsp_tog;
            end
            CMD_SET_DRV: begin
               next_r.dsr = l.cmd_arg[ADDR_HI:ADDR_LO];
            end
            CMD_SELECT: begin
               if (addr_hit && l.cmd_arg[ADDR_HI:ADDR_LO] != ADDR_NONE) begin
                  next_r.selected = 1'b1;
                  if (r.state == ST_STBY) begin
                     next_r.state = ST_TRAN;
                  end
                  if (r.state == ST_DIS) begin
                     next_r.state = ST_PRG;
                  end
                  next_r.busy        = 1'b1;
                  next_r.rsp_kind    = RSP_R1B;
                  next_r.rsp_payload = {96'h0, status};
                  next_r.rsp_tog     = ~r.rsp_tog;
               end else begin
                  next_r.selected = 1'b0;
                  if (r.state == ST_TRAN || r.state == ST_DATA) begin
                     next_r.state = ST_STBY;
                  end
                  if (r.state == ST_PRG) begin
                     next_r.state = ST_DIS;
                  end
               end
            end
            CMD_IF_COND: begin
               next_r.vhs_ok      = host_supply_voltage_code != 4'h0 && (host_supply_voltage_code & ~i_vhs_accepted) == 4'h0;
               next_r.rsp_kind    = RSP_R7;
               next_r.rsp_payload = {96'h0, 20'h00000, next_r.vhs_ok ? host_supply_voltage_code : 4'h0,
                                     l.cmd_arg[PAT_HI:PAT_LO]};
               next_r.rsp_tog     = ~r.rsp_tog;
            end
            CMD_SEND_SPEC, CMD_SEND_IDEN: begin
               if (addr_hit && r.state == ST_STBY) begin
                  next_r.rsp_kind    = RSP_R2;
                  next_r.rsp_payload = (l.cmd_idx == CMD_SEND_SPEC) ? i_card_specific_data
                                                                    : i_card_identification;
                  next_r.rsp_tog     = ~r.rsp_tog;
               end
            end
            CMD_VSWITCH: begin
               next_r.sw18        = 1'b1;
               next_r.rsp_kind    = RSP_R1;
               next_r.rsp_payload = {96'h0, status};
               next_r.rsp_tog     = ~r.rsp_tog;
            end
            CMD_STOP: begin
               next_r.stop = 1'b1;
               if (r.state == ST_DATA) begin
                  next_r.state = ST_TRAN;
               end
               next_r.busy        = 1'b1;
               next_r.rsp_kind    = RSP_R1B;
               next_r.rsp_payload = {96'h0, status};
               next_r.rsp_tog     = ~r.rsp_tog;
            end
            default: begin
               next_r.stop = 1'b0;
            end
         endcase
      end
      if (!i_rst_b) begin
         next_r = '0;
         next_r.state    = ST_IDLE;
         next_r.dsr      = DRV_RESET;
         next_r.rsp_kind = RSP_R1;
      end
   end
   always_ff @(posedge i_core_clk) begin
      r <= next_r;
   end

   assign core_rsp_tog            = r.rsp_tog;
   assign core_busy               = r.busy;
   assign o_state                 = r.state;
   assign o_relative_card_address = r.relative_card_address;
   assign o_driver_stage          = r.dsr;
   assign o_selected              = r.selected;
   assign o_vhs_ok                = r.vhs_ok;
   assign o_switch_18v            = r.sw18;
   assign o_stop_xfer             = r.stop;
   assign o_busy                  = r.busy;
endmodule

// file: mcb_basic_cmd_checker.sv
// concurrent checks on the basic command block ports
`timescale 1ns/100ps
module mcb_basic_cmd_checker (
   input  wire logic          i_core_clk,
   input  wire logic          i_rst_b,
   input  wire logic          i_link_clk,
   input  wire logic          o_rsp_valid,
   input  mcb_pkg::mcb_rsp_e  o_rsp_kind,
   input  wire logic [127:0]  o_rsp_payload,
   input  wire logic          o_dat0_oe,
   input  wire logic [127:0]  i_card_specific_data,
   input  wire logic [127:0]  i_card_identification,
   input  mcb_pkg::mcb_state_e o_state,
   input  wire logic [15:0]   o_relative_card_address,
   input  wire logic          o_selected,
   input  wire logic          o_vhs_ok,
   input  wire logic          o_stop_xfer,
   input  wire logic          o_busy
);
   import mcb_pkg::*;
   // link side leaves reset a few link edges after the core does
   logic [2:0] link_age = 3'h0;
   logic       link_ok;
   always_ff @(posedge i_link_clk) begin
      if (!i_rst_b) begin
         link_age <= 3'h0;
      end else if (link_age != 3'h7) begin
         link_age <= link_age + 3'h1;
      end
   end
   assign link_ok = i_rst_b && link_age == 3'h7;
   // busy rises and stays long enough to reach the link side
   sequence busy_held;
      $rose(o_busy) ##1 o_busy [*3];
   endsequence
   AST_RSP_ONE: assert property (@(posedge i_link_clk) disable iff (!link_ok)
      o_rsp_valid |=> !o_rsp_valid) else $error("long rsp");
   AST_KIND_HOLD: assert property (@(posedge i_link_clk) disable iff (!link_ok)
      !o_rsp_valid |-> $stable(o_rsp_kind)) else $error("kind moved");
   AST_R6_ADDR: assert property (@(posedge i_link_clk) disable iff (!link_ok)
      o_rsp_valid && o_rsp_kind == RSP_R6 |-> o_rsp_payload[31:16] == o_relative_card_address) else $error("r6 addr");
   AST_R7_VHS: assert property (@(posedge i_link_clk) disable iff (!link_ok)
      o_rsp_valid && o_rsp_kind == RSP_R7 |-> o_rsp_payload[11:8] == 4'h0 || o_vhs_ok) else $error("r7 code");
   AST_R2_DATA: assert property (@(posedge i_link_clk) disable iff (!link_ok)
      o_rsp_valid && o_rsp_kind == RSP_R2 |-> o_rsp_payload == i_card_specific_data
      || o_rsp_payload == i_card_identification) else $error("r2 data");
   AST_STOP_BUSY: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      o_stop_xfer |-> ##[0:1] o_busy) else $error("stop busy");
   AST_OE_FOLLOW: assert property (@(posedge i_link_clk) disable iff (!link_ok)
      busy_held |-> ##[0:4] o_dat0_oe) else $error("no busy drive");
   AST_IDLE_DESEL: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      o_state == ST_IDLE |-> !o_selected) else $error("idle selected");
endmodule

bind mcb_basic_cmd mcb_basic_cmd_checker u_chk (.i_core_clk, .i_rst_b, .i_link_clk, .o_rsp_valid, .o_rsp_kind,
   .o_rsp_payload, .o_dat0_oe, .i_card_specific_data, .i_card_identification, .o_state, .o_relative_card_address,
   .o_selected, .o_vhs_ok, .o_stop_xfer, .o_busy);

// file: mcb_basic_cmd_tb_top.sv
// self-checking bench for the basic command block
`timescale 1ns/100ps
module mcb_basic_cmd_tb_top;
   import mcb_pkg::*;
   logic i_core_clk, i_link_clk, i_rst_b, i_data_start, i_prog_start, i_op_done, i_cmd_valid, o_rsp_valid;
   logic o_dat0_out, o_dat0_oe, o_selected, o_vhs_ok, o_switch_18v, o_stop_xfer, o_busy;
   logic [5:0]   i_cmd_index;
   logic [31:0]  i_cmd_arg;
   logic [15:0]  i_new_address, o_relative_card_address, o_driver_stage, a;
   logic [3:0]   i_vhs_accepted, v;
   logic [7:0]   p;
   logic [4:0]   k;
   logic [127:0] i_card_specific_data, i_card_identification, o_rsp_payload, y;
   mcb_rsp_e     o_rsp_kind;
   mcb_state_e   o_state;
   logic         i_dat0_in = 1'h1;
   int           miscompares = 0;
   int           tests_run = 0;
   int           stops = 0;
   mcb_basic_cmd u_mcb_basic_cmd (.i_core_clk, .i_rst_b, .i_link_clk, .i_cmd_valid, .i_cmd_index, .i_cmd_arg,
      .o_rsp_valid, .o_rsp_kind, .o_rsp_payload, .i_dat0_in, .o_dat0_out, .o_dat0_oe, .i_new_address,
      .i_vhs_accepted, .i_card_specific_data, .i_card_identification, .i_data_start, .i_prog_start, .i_op_done,
      .o_state, .o_relative_card_address, .o_driver_stage, .o_selected, .o_vhs_ok, .o_switch_18v, .o_stop_xfer,
      .o_busy);
   mcb_host_model u_mcb_host_model (.i_link_clk, .i_rsp_valid(o_rsp_valid), .i_rsp_kind(o_rsp_kind),
      .i_rsp_payload(o_rsp_payload), .o_cmd_valid(i_cmd_valid), .o_cmd_index(i_cmd_index), .o_cmd_arg(i_cmd_arg));
   initial begin
      i_core_clk = 1'h0;
      forever #20 i_core_clk = ~i_core_clk;
   end
   initial begin
      i_link_clk = 1'h0;
      #7;
      forever #24 i_link_clk = ~i_link_clk;
   end
   // stop pulses last one core cycle, so count them as they pass
   always @(posedge i_core_clk) begin
      if (o_stop_xfer === 1'h1) stops++;
   end
   initial begin
      #150000;
      miscompares++;
      results();
   end
   ////////////////////////////////////////////////////////////
   task chk(input logic [127:0] g, input logic [127:0] e);
      tests_run++;
      if (g !== e) begin
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
         miscompares++;
      end
   endtask
   task cmd(input logic [5:0] i, input logic [31:0] x, input logic r);
      u_mcb_host_model.issue(i, x);
      k = u_mcb_host_model.kind;
      y = u_mcb_host_model.pay;
      chk(u_mcb_host_model.seen, r);
   endtask
   // w: 0 op done, 1 prog start, 2 data start
   task pulse(input int w);
      @(posedge i_core_clk);
      {i_data_start, i_prog_start, i_op_done} <= 3'h1 << w;
      @(posedge i_core_clk);
      {i_data_start, i_prog_start, i_op_done} <= 3'h0;
      repeat (8) @(posedge i_core_clk);
   endtask
   function logic [11:0] r7(input logic [3:0] c, input logic [3:0] m, input logic [7:0] q);
      return {(c & m) != 4'h0 ? c : 4'h0, q};
   endfunction
   task results();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      i_rst_b = 1'h0;
      {i_data_start, i_prog_start, i_op_done} = 3'h0;
      void'($urandom(27138));
      i_new_address = 16'($urandom) | 16'h0001;
      i_vhs_accepted = 4'($urandom);
      i_card_specific_data = {$urandom, $urandom, $urandom, $urandom};
      i_card_identification = {$urandom, $urandom, $urandom, $urandom};
      repeat (2) @(posedge i_core_clk);
      i_rst_b <= 1'h1;
      repeat (4) @(posedge i_link_clk);
      chk({o_state, o_driver_stage}, {ST_IDLE, DRV_RESET});
      for (int n = 0; n < 4; n++) begin
         v = 4'h1 << n;
         p = 8'($urandom);
         cmd(CMD_IF_COND, {20'($urandom), v, p}, 1'h1);
         chk({k, y[11:0]}, {RSP_R7, r7(v, i_vhs_accepted, p)});
         chk(o_vhs_ok, (v & i_vhs_accepted) != 4'h0);
      end
      cmd(CMD_PUB_ADDR, $urandom, 1'h1);
      chk({k, y[31:16], o_state}, {RSP_R6, i_new_address, ST_STBY});
      chk(o_relative_card_address, i_new_address);
      a = 16'($urandom);
      cmd(CMD_SET_DRV, {a, 16'($urandom)}, 1'h0);
      chk(o_driver_stage, a);
      cmd(CMD_SEND_SPEC, {i_new_address, 16'($urandom)}, 1'h1);
      chk(y, i_card_specific_data);
      cmd(CMD_SEND_IDEN, {i_new_address, 16'($urandom)}, 1'h1);
      chk(y, i_card_identification);
      cmd(CMD_SEND_SPEC, {~i_new_address, 16'h0}, 1'h0);
      cmd(CMD_SELECT, {~i_new_address, 16'h0}, 1'h0);
      chk({o_state, o_selected}, {ST_STBY, 1'h0});
      cmd(CMD_SELECT, {i_new_address, 16'($urandom)}, 1'h1);
      chk({k, o_state, o_selected, o_dat0_oe}, {RSP_R1B, ST_TRAN, 2'h3});
      chk({y[12:9], o_dat0_out}, {CODE_STBY, 1'h0});
      pulse(0);
      chk(o_dat0_oe, 1'h0);
      pulse(1);
      chk({o_state, o_busy, o_dat0_oe}, {ST_PRG, 2'h3});
      cmd(CMD_SELECT, {~i_new_address, 16'h0}, 1'h0);
      chk({o_state, o_selected}, {ST_DIS, 1'h0});
      cmd(CMD_SELECT, {i_new_address, 16'($urandom)}, 1'h1);
      chk({k, o_state, o_selected, y[12:9]}, {RSP_R1B, ST_PRG, 1'h1, CODE_DIS});
      pulse(0);
      chk(o_state, ST_TRAN);
      pulse(2);
      cmd(CMD_STOP, $urandom, 1'h1);
      chk({k, o_busy, o_dat0_oe}, {RSP_R1B, 2'h3});
      chk({o_state, 8'(stops)}, {ST_TRAN, 8'h01});
      pulse(0);
      chk(o_dat0_oe, 1'h0);
      cmd(CMD_VSWITCH, $urandom, 1'h1);
      chk({k, o_switch_18v}, {RSP_R1, 1'h1});
      chk(y[12:9], CODE_TRAN);
      cmd(CMD_SELECT, 32'h0, 1'h0);
      chk(o_selected, 1'h0);
      cmd(CMD_GO_IDLE, $urandom, 1'h0);
      chk({o_state, o_relative_card_address}, {ST_IDLE, ADDR_NONE});
      results();
   end
endmodule

// file: mcb_host_model.sv
// host model issuing decoded commands on the link clock
`timescale 1ns/100ps
module mcb_host_model (
   input  wire logic         i_link_clk,
   input  wire logic         i_rsp_valid,
   input  wire logic [4:0]   i_rsp_kind,
   input  wire logic [127:0] i_rsp_payload,
   output logic              o_cmd_valid,
   output logic [5:0]        o_cmd_index,
   output logic [31:0]       o_cmd_arg
);
   import mcb_pkg::*;
   logic         seen;
   logic [4:0]   kind;
   logic [127:0] pay;
   initial {o_cmd_valid, o_cmd_index, o_cmd_arg} = 39'h0;
   // one command, then a quiet gap wider than the minimum spacing
   task automatic issue(input logic [5:0] idx, input logic [31:0] arg);
      logic [31:0] a;
      a = arg;
      if (idx == CMD_IF_COND) a[31:12] = 20'h0;
      if (idx == CMD_VSWITCH) a = 32'h0;
      seen = 1'h0;
      @(posedge i_link_clk);
      {o_cmd_valid, o_cmd_index, o_cmd_arg} <= {1'h1, idx, a};
      @(posedge i_link_clk);
      {o_cmd_valid, o_cmd_index, o_cmd_arg} <= {1'h0, ~idx, ~a};
      repeat (14) begin
         @(negedge i_link_clk);
         if (i_rsp_valid) {seen, kind, pay} = {1'h1, i_rsp_kind, i_rsp_payload};
      end
   endtask
endmodule

// file: mcb_sync.sv
// package for the basic command block and its two-stage synchroniser
package mcb_pkg;
   localparam logic [5:0]   CMD_GO_IDLE   = 6'h00;
   localparam logic [5:0]   CMD_PUB_ADDR  = 6'h03;
   localparam logic [5:0]   CMD_SET_DRV   = 6'h04;
   localparam logic [5:0]   CMD_SELECT    = 6'h07;
   localparam logic [5:0]   CMD_IF_COND   = 6'h08;
   localparam logic [5:0]   CMD_SEND_SPEC = 6'h09;
   localparam logic [5:0]   CMD_SEND_IDEN = 6'h0A;
   localparam logic [5:0]   CMD_VSWITCH   = 6'h0B;
   localparam logic [5:0]   CMD_STOP      = 6'h0C;
   localparam int           ADDR_HI       = 31;
   localparam int           ADDR_LO       = 16;
   localparam int           VHS_HI        = 11;
   localparam int           VHS_LO        = 8;
   localparam int           PAT_HI        = 7;
   localparam int           PAT_LO        = 0;
   localparam logic [15:0]  DRV_RESET     = 16'h0404;
   localparam logic [15:0]  ADDR_NONE     = 16'h0000;
   localparam logic [3:0]   CODE_IDLE     = 4'h0;
   localparam logic [3:0]   CODE_STBY     = 4'h3;
   localparam logic [3:0]   CODE_TRAN     = 4'h4;
   localparam logic [3:0]   CODE_DATA     = 4'h5;
   localparam logic [3:0]   CODE_PRG      = 4'h7;
   localparam logic [3:0]   CODE_DIS      = 4'h8;
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_STBY = 6'h02,
      ST_TRAN = 6'h04,
      ST_DATA = 6'h08,
      ST_PRG  = 6'h10,
      ST_DIS  = 6'h20
   } mcb_state_e;
   typedef enum logic [4:0] {
      RSP_R1  = 5'h01,
      RSP_R1B = 5'h02,
      RSP_R2  = 5'h04,
      RSP_R6  = 5'h08,
      RSP_R7  = 5'h10
   } mcb_rsp_e;
endpackage

`timescale 1ns/100ps
module mcb_sync #(
   parameter int W = 1
) (
   input  wire logic          i_clk,
   input  wire logic [W-1:0]  i_d,
   output logic      [W-1:0]  o_q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stab;
   } mcb_sync_s;
   mcb_sync_s r;
   mcb_sync_s next_r;
   always_comb begin
      next_r.meta = i_d;
      next_r.stab = r.meta;
   end
   always_ff @(posedge i_clk) begin
      r <= next_r;
   end
   assign o_q = r.stab;
endmodule
